/* File: dv/i2c_far_master.sv */
// Purpose: Far-side bus master that sends a start, one address byte, the ack slot and a stop.
// Assumes: Bench resolves both lines with pull-ups; bit time 125 ns, unrelated to aclk.
// Notes:   Every clock rise waits out stretching, with a bound so a stuck line cannot hang it.
`timescale 1ns/1ps
module i2c_far_master (
   // Bus lines
   input  wire logic scl,
   input  wire logic sda,
   // Pull-down enables
   output logic      scl_dn,
   output logic      sda_dn,
   // Observation
   output int        fall_cnt,
   output logic      ack_low
);
   initial scl_dn = 0;
   initial sda_dn = 0;
   initial ack_low = 0;
   task automatic rise();
      scl_dn = 0;
      for (int k = 0; k < 4000 && scl !== 1'b1; k++) #10;
      #62.5;
   endtask
   task automatic frame(input logic [7:0] a);
      sda_dn = 1;
      #62.5;
      scl_dn = 1;
      fall_cnt = 0;
      for (int j = 0; j < 10; j++) begin
         #31.25;
         sda_dn = (j < 8) ? !a[7-j] : (j == 9);
         #31.25;
         rise();
         if (j == 8) ack_low = !sda;
         scl_dn = (j < 9);
         fall_cnt = fall_cnt + (j < 9);
      end
      // Stop: data released while the clock is high
      sda_dn = 0;
      #62.5;
   endtask
endmodule

/* File: dv/i2c_wait_irq_arbitration_test.sv */
// Purpose: Slave-side checks of interrupt timing, waits, releases, flags and extension codes.
// Assumes: Lines are open drain with pull-ups; own address kept clear of extension nibbles.
// Notes:   Master-role and arbitration paths rely on the in-design assertions only.
`timescale 1ns/1ps
module i2c_wait_irq_arbitration_test;
   import i2c_ctrl_pkg::*;
   logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata, d, rv;
   logic [1:0]        bresp, rresp, r;
   logic              awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, bus_interrupt;
   logic              scl_dn, sda_dn, ack_low;
   logic [7:0]        own;
   logic [7:0]        tbl [0:12];
   wire logic         scl_w = !(scl_oe | scl_dn);
   wire logic         sda_w = !(sda_oe | sda_dn);
   int                fall_cnt, irq_n, irq_fall, fails, check_count;
   integer            seed = 32'h2b5f;
   i2c_wait_irq_arbitration i2c_wait_irq_arbitration_inst (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w),
      .sda_o(), .sda_oe(sda_oe), .bus_interrupt(bus_interrupt));
   i2c_far_master i2c_far_master_inst (.scl(scl_w), .sda(sda_w), .scl_dn(scl_dn), .sda_dn(sda_dn),
      .fall_cnt(fall_cnt), .ack_low(ack_low));
   initial begin
      aclk = 0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) if (bus_interrupt === 1'b1) begin
      irq_n <= irq_n + 1;
      irq_fall <= fall_cnt;
   end
   task automatic close_out(input bit to);
      if (to) fails++;
      $display("fails=%0d check_count=%0d", fails, check_count);
      if (fails == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         $display("Error t=%0t got %h exp %h", $time, g, e);
         fails++;
      end
   endtask
   // Ready is sampled mid-cycle, where it is settled, and acted on at the next rise
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
      bit ta, tw, b;
      b = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      for (int k = 0; k < 50 && !b; k++) begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         b = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
         if (b) bready <= 0;
      end
      if (!b) close_out(1);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      bit ta, b;
      b = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      for (int k = 0; k < 50 && !b; k++) begin
         @(negedge aclk);
         ta = arvalid & arready;
         b = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 0;
         if (b) rready <= 0;
      end
      if (!b) close_out(1);
   endtask
   function automatic logic [7:0] fix(input logic [7:0] a);
      return (a[7:4] == 4'h0 || a[7:4] == 4'hf) ? a ^ 8'h40 : a;
   endfunction
   function automatic logic [2:0] cls(input logic [7:0] a);
      if (a[7:1] == 7'h00) return a[0] ? EXT_START_BY : EXT_GEN_CALL;
      if (a[7:1] == 7'h01) return EXT_OTHER_BF;
      if (a[7:1] == 7'h02) return EXT_RESERVED;
      if (a[7:3] == 5'h1e) return EXT_TEN_BIT;
      return (fix(a) != a) ? EXT_UNKNOWN : EXT_NONE;
   endfunction
   task automatic frame(input logic [7:0] a, input bit sie, input bit rel);
      bit ext, mt;
      int n0;
      ext = fix(a) != a;
      mt = !ext && a[7:1] == own[7:1];
      wr(CTRL_OFS, {3'b100, sie, 4'h0});
      n0 = irq_n;
      fork
         i2c_far_master_inst.frame(a);
         begin
            for (int k = 0; k < 400 && irq_n == n0; k++) @(posedge aclk);
            if (ext | mt) begin
               if (irq_n == n0) close_out(1);
               chk(irq_fall, ext ? 8 : 9);
               repeat (4) @(posedge aclk);
               chk(scl_oe, 1);
               rd(STAT_OFS);
               chk(d[5:4], {ext, mt});
               chk(d[1], 1);
               rd(EXT_OFS);
               chk(d, cls(a));
               if (ext) wr(CTRL_OFS, {3'b110, sie, 4'h0});
               // A transmitting slave is released with all ones, else its data could block the stop
               else if (rel || a[0]) wr(SHIFT_OFS, 8'hff);
               else wr(CTRL_OFS, {3'b101, sie, 4'h0});
               repeat (3) @(posedge aclk);
               chk(scl_oe, 0);
            end
         end
      join
      repeat (10) @(posedge aclk);
      chk(ack_low, mt);
      chk(irq_n - n0, (ext | mt) + sie);
      rd(STAT_OFS);
      chk(d[0], 1);
      wr(STAT_OFS, 8'hff);
   endtask
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, aresetn} = 0;
      {awaddr, araddr, wdata} = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      rd(CTRL_OFS);
      chk(d, CTRL_RESET);
      rd(OWN_OFS);
      chk(d, OWN_RESET);
      rd(5'h14);
      chk(r, RESP_SLVERR);
      rv = $random(seed);
      own = fix(rv[7:0]);
      wr(OWN_OFS, own);
      chk(r, RESP_OKAY);
      tbl = '{own, own ^ 8'h02, 8'h00, 8'h01, 8'h02, 8'h04, 8'hf0, 8'hf6, 8'hf8, 0, 0, 0, 0};
      for (int i = 9; i < 13; i++) begin
         rv = $random(seed);
         tbl[i] = fix(rv[7:0]);
      end
      foreach (tbl[i]) begin
         rv = $random(seed);
         frame(tbl[i], rv[8], i % 2);
      end
      close_out(0);
   end
endmodule

/* File: include/i2c_ctrl_pkg.sv */
// Purpose: Shared constants and types of the two-wire bus control core.
// Assumes: 100 MHz system clock, AXI4-Lite register access with 32-bit data.
// Notes:   Registers hold 8 bits in the low byte of each word.
package i2c_ctrl_pkg;

   localparam int ADDR_W = 5;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] CTRL_OFS  = 5'h00;
   localparam logic [ADDR_W-1:0] STAT_OFS  = 5'h04;
   localparam logic [ADDR_W-1:0] SHIFT_OFS = 5'h08;
   localparam logic [ADDR_W-1:0] OWN_OFS   = 5'h0c;
   localparam logic [ADDR_W-1:0] EXT_OFS   = 5'h10;

   // Control register fields
   localparam int CTRL_ENABLE_BIT       = 7;
   localparam int CTRL_BUS_RELEASE_BIT  = 6;
   localparam int CTRL_WAIT_RELEASE_BIT = 5;
   localparam int CTRL_STOP_IRQ_EN_BIT  = 4;
   localparam int CTRL_WAIT_TIMING_BIT  = 3;
   localparam int CTRL_AUTO_ACK_BIT     = 2;
   localparam int CTRL_START_BIT        = 1;
   localparam int CTRL_STOP_BIT         = 0;

   // Status register fields
   localparam int STAT_MASTER_BIT   = 7;
   localparam int STAT_ARB_LOST_BIT = 6;
   localparam int STAT_EXT_BIT      = 5;
   localparam int STAT_MATCH_BIT    = 4;
   localparam int STAT_TX_BIT       = 3;
   localparam int STAT_ACK_BIT      = 2;
   localparam int STAT_START_BIT    = 1;
   localparam int STAT_STOP_BIT     = 0;

   // Reset values
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam logic [7:0] OWN_RESET   = 8'h00;
   localparam logic [7:0] SHIFT_RESET = 8'h00;

   // Serial clock numbering within a byte
   localparam logic [3:0] CLK_EIGHTH = 4'h8;
   localparam logic [3:0] CLK_NINTH  = 4'h9;

   // Extension code classes
   localparam logic [2:0] EXT_NONE     = 3'h0;
   localparam logic [2:0] EXT_GEN_CALL = 3'h1;
   localparam logic [2:0] EXT_START_BY = 3'h2;
   localparam logic [2:0] EXT_OTHER_BF = 3'h3;
   localparam logic [2:0] EXT_RESERVED = 3'h4;
   localparam logic [2:0] EXT_TEN_BIT  = 3'h5;
   localparam logic [2:0] EXT_UNKNOWN  = 3'h6;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCL_HALF_NS   = 5000;
   localparam int SCL_HALF_CYC  = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {M_IDLE, M_START, M_LOW, M_HIGH, M_RS1, M_RS2, M_SP1, M_SP2, M_SP3} master_state_t;

endpackage

/* File: logic/i2c_wait_irq_arbitration.sv */
// Purpose: Two-wire bus controller core: interrupt and wait timing, address match,
//          extension codes, transmit readback and multi-master arbitration.
// Assumes: Bus lines are open drain with pull-ups; scl_i and sda_i are asynchronous.
// Notes:   Control bits and status flags sit in the low byte of each register word.
// Overview of operation
// - Data phases interrupt and wait at 8th fall, or 9th when wait timing set.
// - Master address byte always interrupts and waits at the 9th fall.
// - Slave own-address match forces acknowledge, then interrupt and wait at 9th fall.
// - Slave receiving an extension code interrupts at the 8th fall.
// - Mismatch after repeated start interrupts at 9th fall without a wait.
// - Mismatch that is no extension code gives no wait, and no interrupt unless it follows a repeated start.
// - Interrupts and wait starts follow a serial clock falling edge, save the stop interrupt and the wait at the end of a master start.
// - Writing wait_release (control bit 5) ends a pending wait.
// - Any shift register write ends a pending wait.
// - As master, start or stop request also ends a pending wait.
// - With 8-clock wait, acknowledge level is auto_ack_enable at release time.
// - Stop detection interrupts only when stop_irq_enable is set.
// - Transmitted bits are read back from the data line into the shift register.
// - Upper nibble 0000 or 1111 sets extension flag, interrupts at 8th fall.
// - Ten-bit prefix: nibble match sets extension, seven-bit match sets address match.
// - Extension flag is status bit 5, address match flag status bit 4.
// - bus_release_request drops slave role, releases lines, waits for next frame.
// - Extension codes are classified: call, start byte, other bus, reserved, ten-bit.
// - Master compares each sent bit; on loss flags it and releases both lines.
// - After loss, interrupt at 8th or 9th fall, or at stop when enabled.
// - A wait holds the serial clock line low until released.
// - Start condition sets start flag, status bit 1.
// - Stop condition sets stop flag, status bit 0.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module i2c_wait_irq_arbitration
   import i2c_ctrl_pkg::*;
(
   // Clock and reset
   input  logic              aclk,
   input  logic              aresetn,
   // AXI4-Lite write
   input  logic [ADDR_W-1:0] awaddr,
   input  logic              awvalid,
   output logic              awready,
   input  logic [31:0]       wdata,
   input  logic [3:0]        wstrb,
   input  logic              wvalid,
   output logic              wready,
   output logic [1:0]        bresp,
   output logic              bvalid,
   input  logic              bready,
   // AXI4-Lite read
   input  logic [ADDR_W-1:0] araddr,
   input  logic              arvalid,
   output logic              arready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   output logic              rvalid,
   input  logic              rready,
   // Two-wire bus
   input  logic              scl_i,
   output logic              scl_o,
   output logic              scl_oe,
   input  logic              sda_i,
   output logic              sda_o,
   output logic              sda_oe,
   // Event
   output logic              bus_interrupt
);

   // Line synchronisers and edge history
   logic scl_meta_q, scl_q, scl_prev_q;
   logic sda_meta_q, sda_q, sda_prev_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_meta_q <= 1'b1;
         scl_q      <= 1'b1;
         scl_prev_q <= 1'b1;
         sda_meta_q <= 1'b1;
         sda_q      <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_meta_q <= scl_i;
         scl_q      <= scl_meta_q;
         scl_prev_q <= scl_q;
         sda_meta_q <= sda_i;
         sda_q      <= sda_meta_q;
         sda_prev_q <= sda_q;
      end
   end

   wire scl_rise  = scl_q & ~scl_prev_q;
   wire scl_fall  = ~scl_q & scl_prev_q;
   wire start_det = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
   wire stop_det  = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

   // AXI4-Lite slave
   logic              aw_have_q, w_have_q, bvalid_q, rvalid_q, wstrb0_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [7:0]        wdat_q;
   logic [1:0]        bresp_q, rresp_q;
   logic [31:0]       rdata_q;

   assign awready = ~aw_have_q & ~bvalid_q;
   assign wready  = ~w_have_q & ~bvalid_q;
   assign arready = ~rvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rresp   = rresp_q;
   assign rdata   = rdata_q;

   wire wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
   wire wr_hit   = aw_addr_q inside {CTRL_OFS, STAT_OFS, SHIFT_OFS, OWN_OFS, EXT_OFS};
   wire wr_en    = wr_fire & wstrb0_q;
   wire wr_ctrl  = wr_en & (aw_addr_q == CTRL_OFS);
   wire wr_stat  = wr_en & (aw_addr_q == STAT_OFS);
   wire wr_shift = wr_en & (aw_addr_q == SHIFT_OFS);
   wire wr_own   = wr_en & (aw_addr_q == OWN_OFS);
   wire rd_fire  = arvalid & ~rvalid_q;
   wire rd_hit   = araddr inside {CTRL_OFS, STAT_OFS, SHIFT_OFS, OWN_OFS, EXT_OFS};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_addr_q <= '0;
         wdat_q    <= 8'h00;
         wstrb0_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wdat_q   <= wdata[7:0];
            wstrb0_q <= wstrb[0];
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Control strobes; the request bits act once and read back as zero
   wire rel_req  = wr_ctrl & wdat_q[CTRL_WAIT_RELEASE_BIT];
   wire sta_req  = wr_ctrl & wdat_q[CTRL_START_BIT];
   wire sto_req  = wr_ctrl & wdat_q[CTRL_STOP_BIT];
   wire lrel_req = wr_ctrl & wdat_q[CTRL_BUS_RELEASE_BIT];

   logic       en_q, spie_q, wts_q, acke_q;
   logic [7:0] own_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q   <= CTRL_RESET[CTRL_ENABLE_BIT];
         spie_q <= CTRL_RESET[CTRL_STOP_IRQ_EN_BIT];
         wts_q  <= CTRL_RESET[CTRL_WAIT_TIMING_BIT];
         acke_q <= CTRL_RESET[CTRL_AUTO_ACK_BIT];
         own_q  <= OWN_RESET;
      end else begin
         if (wr_ctrl) begin
            en_q   <= wdat_q[CTRL_ENABLE_BIT];
            spie_q <= wdat_q[CTRL_STOP_IRQ_EN_BIT];
            wts_q  <= wdat_q[CTRL_WAIT_TIMING_BIT];
            acke_q <= wdat_q[CTRL_AUTO_ACK_BIT];
         end
         if (wr_own) begin
            own_q <= wdat_q;
         end
      end
   end

   // Bus-side state
   logic          busy_q, addr_phase_q, restart_q, master_q, selected_q, tx_q;
   logic          wait_q, sda_low_q, ack_rx_q, irq_q, al_pend_q;
   logic          exc_q, coi_q, al_q, std_q, spd_q;
   logic [3:0]    bitn_q;
   logic [7:0]    shift_q;
   logic [2:0]    ext_class_q;
   logic [9:0]    timer_q;
   master_state_t m_state_q;

   // Address decode of the received byte
   wire ext_code  = (shift_q[7:4] == 4'h0) | (shift_q[7:4] == 4'hf);
   wire own_match = shift_q[7:1] == own_q[7:1];
   wire [2:0] ext_class = (shift_q[7:1] == 7'h00) ? (shift_q[0] ? EXT_START_BY : EXT_GEN_CALL) :
                          (shift_q[7:1] == 7'h01) ? EXT_OTHER_BF :
                          (shift_q[7:1] == 7'h02) ? EXT_RESERVED :
                          (shift_q[7:3] == 5'h1e) ? EXT_TEN_BIT : EXT_UNKNOWN;

   wire fall8       = scl_fall & (bitn_q == CLK_EIGHTH);
   wire fall9       = scl_fall & (bitn_q == CLK_NINTH);
   wire slv_listen  = en_q & ~master_q & addr_phase_q;
   wire ext_hit     = slv_listen & fall8 & ext_code;
   wire match_hit   = slv_listen & fall8 & own_match;
   wire data_active = ~addr_phase_q & (master_q | selected_q);
   wire tx_active   = (addr_phase_q & master_q) | (data_active & tx_q);

   // Interrupt and wait points, all taken on a serial clock falling edge except stop_irq, taken on stop detection
   wire irq8  = ext_hit | ((data_active | al_pend_q) & fall8 & ~wts_q);
   wire wait8 = ext_hit | (data_active & fall8 & ~wts_q);
   wire nine_addr = slv_listen & ~exc_q & (selected_q | restart_q);
   wire irq9  = fall9 & ((addr_phase_q & master_q) | nine_addr | ((data_active | al_pend_q) & wts_q));
   wire wait9 = fall9 & ((addr_phase_q & master_q) | (slv_listen & ~exc_q & selected_q) | (data_active & wts_q));
   wire stop_irq = stop_det & spie_q;
   wire irq_d = en_q & (irq8 | irq9 | stop_irq);

   // Master sequencer timing
   wire m_done   = timer_q == 10'(SCL_HALF_CYC - 1);
   wire m_ctl    = m_state_q inside {M_START, M_RS1, M_RS2, M_SP1, M_SP2, M_SP3};
   wire m_sda    = m_state_q inside {M_START, M_SP1, M_SP2};
   wire m_scl    = master_q & (m_state_q inside {M_LOW, M_RS1, M_SP1});
   wire m_wait_h = m_state_q inside {M_HIGH, M_RS2, M_SP2};
   wire start_go = sta_req & en_q & ~busy_q & (m_state_q == M_IDLE);
   wire lose     = master_q & (m_state_q == M_HIGH) & scl_q & ~sda_low_q & ~sda_q & tx_active &
                   (bitn_q != 4'h0) & (bitn_q <= CLK_EIGHTH);
   wire wait_rel = rel_req | wr_shift | lrel_req | (master_q & (sta_req | sto_req));

   // Level wanted on the data line for the current clock slot
   logic sda_want;
   always_comb begin
      sda_want = 1'b0;
      if (bitn_q < CLK_EIGHTH) begin
         sda_want = tx_active & ~shift_q[7];
      end else if (bitn_q == CLK_EIGHTH) begin
         if (addr_phase_q) begin
            sda_want = ~master_q & (selected_q | (exc_q & acke_q));
         end else begin
            sda_want = data_active & ~tx_q & acke_q;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_q       <= 1'b0;
         addr_phase_q <= 1'b0;
         restart_q    <= 1'b0;
         bitn_q       <= 4'h0;
         selected_q   <= 1'b0;
         tx_q         <= 1'b0;
         wait_q       <= 1'b0;
         sda_low_q    <= 1'b0;
         ack_rx_q     <= 1'b0;
         irq_q        <= 1'b0;
         shift_q      <= SHIFT_RESET;
         ext_class_q  <= EXT_NONE;
      end else begin
         irq_q <= irq_d;
         if (start_det) begin
            busy_q       <= 1'b1;
            restart_q    <= busy_q;
            addr_phase_q <= 1'b1;
            bitn_q       <= 4'h0;
            selected_q   <= 1'b0;
         end else if (stop_det) begin
            busy_q       <= 1'b0;
            addr_phase_q <= 1'b0;
            selected_q   <= 1'b0;
         end else if (fall9) begin
            bitn_q       <= 4'h0;
            addr_phase_q <= 1'b0;
            if (addr_phase_q) begin
               tx_q <= master_q ? ~shift_q[0] : shift_q[0];
            end
         end else if (scl_rise && bitn_q < CLK_NINTH) begin
            bitn_q <= bitn_q + 4'h1;
         end
         if (match_hit) begin
            selected_q <= 1'b1;
         end
         if (lrel_req || !en_q) begin
            selected_q <= 1'b0;
         end
         // Class describes the frame in progress, so a new start clears it
         if (start_det) begin
            ext_class_q <= EXT_NONE;
         end else if (ext_hit) begin
            ext_class_q <= ext_class;
         end
         if (start_go) begin
            tx_q <= 1'b1;
         end
         if (wr_shift) begin
            shift_q <= wdat_q;
         end else if (scl_rise && bitn_q < CLK_EIGHTH && busy_q) begin
            shift_q <= {shift_q[6:0], sda_q};
         end
         if (scl_rise && bitn_q == CLK_EIGHTH) begin
            ack_rx_q <= ~sda_q;
         end
         if (!en_q) begin
            wait_q <= 1'b0;
         end else if (wait8 || wait9 || (m_state_q == M_START && m_done)) begin
            wait_q <= 1'b1;
         end else if (wait_rel) begin
            wait_q <= 1'b0;
         end
         // Data line changes only while the clock is low, so no false start or stop
         if (!en_q || lose || lrel_req) begin
            sda_low_q <= 1'b0;
         end else if (!scl_q) begin
            sda_low_q <= sda_want;
         end
      end
   end

   // Master sequencer: start, clocking with stretch tolerance, repeated start, stop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         m_state_q <= M_IDLE;
         timer_q   <= 10'h000;
         master_q  <= 1'b0;
      end else if (!en_q || lose || lrel_req) begin
         m_state_q <= M_IDLE;
         timer_q   <= 10'h000;
         master_q  <= 1'b0;
      end else begin
         timer_q <= (m_done || (m_wait_h && !scl_q)) ? 10'h000 : timer_q + 10'h001;
         case (m_state_q)
            M_IDLE: begin
               timer_q <= 10'h000;
               if (start_go) begin
                  m_state_q <= M_START;
                  master_q  <= 1'b1;
               end
            end
            M_START: if (m_done) m_state_q <= M_LOW;
            M_LOW: begin
               if (wait_q) begin
                  timer_q <= 10'h000;
                  if (sta_req) begin
                     m_state_q <= M_RS1;
                  end else if (sto_req) begin
                     m_state_q <= M_SP1;
                  end
               end else if (m_done) begin
                  m_state_q <= M_HIGH;
               end
            end
            M_HIGH: if (m_done) m_state_q <= M_LOW;
            M_RS1:  if (m_done) m_state_q <= M_RS2;
            M_RS2:  if (m_done) m_state_q <= M_START;
            M_SP1:  if (m_done) m_state_q <= M_SP2;
            M_SP2:  if (m_done) m_state_q <= M_SP3;
            M_SP3: begin
               if (m_done) begin
                  m_state_q <= M_IDLE;
                  master_q  <= 1'b0;
               end
            end
            default: m_state_q <= M_IDLE;
         endcase
      end
   end

   // Sticky flags; a hardware set wins over a clear in the same cycle
   wire [7:0] clr = wr_stat ? wdat_q : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exc_q     <= 1'b0;
         coi_q     <= 1'b0;
         al_q      <= 1'b0;
         al_pend_q <= 1'b0;
         std_q     <= 1'b0;
         spd_q     <= 1'b0;
      end else begin
         exc_q <= ext_hit | (exc_q & ~clr[STAT_EXT_BIT] & ~start_det & ~stop_det);
         coi_q <= match_hit | (coi_q & ~clr[STAT_MATCH_BIT] & ~start_det & ~stop_det);
         al_q  <= lose | (al_q & ~clr[STAT_ARB_LOST_BIT] & en_q);
         al_pend_q <= lose | (al_pend_q & ~irq_d & ~stop_det);
         std_q <= start_det | (std_q & ~clr[STAT_START_BIT]);
         spd_q <= stop_det | (spd_q & ~clr[STAT_STOP_BIT] & ~start_det);
      end
   end

   wire [7:0] status = {master_q, al_q, exc_q, coi_q, tx_q, ack_rx_q, std_q, spd_q};
   wire [7:0] ctrl   = {en_q, 2'h0, spie_q, wts_q, acke_q, 2'h0};
   wire [7:0] rd_byte = (araddr == CTRL_OFS)  ? ctrl :
                        (araddr == STAT_OFS)  ? status :
                        (araddr == SHIFT_OFS) ? shift_q :
                        (araddr == OWN_OFS)   ? own_q :
                        (araddr == EXT_OFS)   ? {5'h00, ext_class_q} : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         rdata_q  <= {24'h00_0000, rd_byte};
         rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Open-drain drive: a wait or the master low phase pulls the clock down
   assign scl_o         = 1'b0;
   assign sda_o         = 1'b0;
   assign scl_oe        = m_scl | wait_q;
   assign sda_oe        = (master_q && m_ctl) ? m_sda : sda_low_q;
   assign bus_interrupt = irq_q;

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_wait_holds_scl: assert property (wait_q |-> scl_oe)
      else $error("wait active but clock line not held");
   chk_irq_on_edge: assert property (irq_q |-> $past(scl_fall) || $past(stop_det))
      else $error("interrupt not aligned to clock fall or stop");
   chk_data_wait_timing: assert property (en_q && data_active && fall8 && !wts_q |=> wait_q && irq_q)
      else $error("8-clock wait missed in data phase");
   chk_master_addr_nine: assert property (en_q && addr_phase_q && master_q && fall8 |=> !irq_q)
      else $error("master address interrupted at 8th clock");
   chk_match_ack: assert property (match_hit && !ext_code |-> ##2 sda_oe)
      else $error("own address not acknowledged");
   chk_ext_flag: assert property (ext_hit |=> exc_q && irq_q && wait_q)
      else $error("extension code not flagged at 8th clock");
   chk_silent_mismatch: assert property (slv_listen && fall8 && !own_match && !ext_code && !al_pend_q |=> !irq_q && !wait_q)
      else $error("mismatched address raised an event");
   chk_release_bit: assert property (wait_q && rel_req |=> !wait_q)
      else $error("wait_release did not end wait");
   chk_shift_release: assert property (wait_q && wr_shift |=> !wait_q)
      else $error("shift write did not end wait");
   chk_stop_irq_gate: assert property (stop_det && en_q |=> irq_q == $past(spie_q))
      else $error("stop interrupt not gated by enable");
   chk_arb_release: assert property (lose |=> !sda_oe && !m_scl && al_q)
      else $error("lines not released after arbitration loss");
   chk_start_flag: assert property (start_det |=> std_q)
      else $error("start flag not set");

   cov_master_addr: cover property (addr_phase_q && master_q && fall9);
   cov_slave_match: cover property (match_hit && !ext_code);
   cov_ext_code:    cover property (ext_hit);
   cov_arb_lost:    cover property (lose);

endmodule
